/* File: ptd_pkg.sv */
// Package with register map, field layout and reset values of the pin transition detector.
package ptd_pkg;
    localparam int PTD_CH = 8;
    localparam logic [8:0] PTD_ADDR_FLAG = 9'h04F;
    localparam logic [8:0] PTD_ADDR_SEL = 9'h16E;
    localparam logic [8:0] PTD_ADDR_MASK = 9'h170;
    localparam logic [7:0] PTD_FLAG_RST = 8'h00;
    localparam logic [15:0] PTD_SEL_RST = 16'h0000;
    localparam logic [7:0] PTD_MASK_RST = 8'h00;
    localparam int PTD_SEL_W = 2;
    localparam logic [1:0] PTD_EDGE_FALL = 2'h0;
    localparam logic [1:0] PTD_EDGE_RISE = 2'h1;
    localparam logic [1:0] PTD_EDGE_BOTH = 2'h2;
endpackage : ptd_pkg

/* File: ptd_top.sv */
// Eight-channel pin transition detector with register port and interrupt.
// Functional notes
// - Eight channels, each rising, falling or both.
// - Valid edge on channel n sets flag n.
// - Flags stay set until software writes zero.
// - Every reset clears the flag register.
// - Edge select register is word access only.
// - Reset loads edge select with falling edges.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module ptd_top
    import ptd_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Edge input pins.
    input wire logic [7:0] edge_input_pins,
    // Register port.
    input wire logic [8:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_word,
    output logic [15:0] reg_rdata,
    // Interrupt.
    output logic irq
);
    import ptd_pkg::*;

    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [7:0] prev_q;
    logic [7:0] hit;
    logic [7:0] edge_flag_bits_q;
    logic [7:0] edge_flag_bits_d;
    logic [15:0] edge_select_control_q;
    logic [7:0] mask_q;
    logic [7:0] mask_d;
    logic wr_flag;
    logic wr_sel;
    logic wr_mask;

    assign wr_flag = reg_wr && (reg_addr == PTD_ADDR_FLAG);
    assign wr_sel = reg_wr && reg_word && (reg_addr == PTD_ADDR_SEL);
    assign wr_mask = reg_wr && (reg_addr == PTD_ADDR_MASK);

    // Two-stage synchroniser, then a third stage holds the previous sample.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            prev_q <= 8'h00;
        end else begin
            sync1_q <= edge_input_pins;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    always_comb begin
        for (int i = 0; i < PTD_CH; i++) begin
            case (edge_select_control_q[i*PTD_SEL_W +: PTD_SEL_W])
                PTD_EDGE_FALL: hit[i] = prev_q[i] && !sync2_q[i];
                PTD_EDGE_RISE: hit[i] = !prev_q[i] && sync2_q[i];
                PTD_EDGE_BOTH: hit[i] = prev_q[i] ^ sync2_q[i];
                default: hit[i] = prev_q[i] ^ sync2_q[i];
            endcase
        end
    end

    // Writing zero clears a flag, writing one leaves it; a new edge wins.
    always_comb begin
        edge_flag_bits_d = edge_flag_bits_q;
        if (wr_flag) begin
            edge_flag_bits_d = edge_flag_bits_q & reg_wdata[7:0];
        end
        edge_flag_bits_d = edge_flag_bits_d | hit;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            edge_flag_bits_q <= PTD_FLAG_RST;
        end else begin
            edge_flag_bits_q <= edge_flag_bits_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            edge_select_control_q <= PTD_SEL_RST;
        end else if (wr_sel) begin
            edge_select_control_q <= reg_wdata;
        end
    end

    // Next mask value, so that irq follows a mask write in the same cycle as the mask register.
    always_comb begin
        mask_d = mask_q;
        if (wr_mask) begin
            mask_d = reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mask_q <= PTD_MASK_RST;
        end else if (wr_mask) begin
            mask_q <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                PTD_ADDR_FLAG: reg_rdata <= {8'h00, edge_flag_bits_q};
                PTD_ADDR_SEL: reg_rdata <= reg_word ? edge_select_control_q : 16'h0000;
                PTD_ADDR_MASK: reg_rdata <= {8'h00, mask_q};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(edge_flag_bits_d & mask_d);
        end
    end

    // Flag register behaviour.
    a_flag_sets: assert property (
        @(posedge clk) disable iff (!nrst)
        (hit != 8'h00) |=> ((edge_flag_bits_q & $past(hit)) == $past(hit)))
        else $error("edge did not set its flag");

    a_flag_sticky: assert property (
        @(posedge clk) disable iff (!nrst)
        !wr_flag |=> ((edge_flag_bits_q & $past(edge_flag_bits_q)) == $past(edge_flag_bits_q)))
        else $error("flag cleared without a write");

    a_flag_clear: assert property (
        @(posedge clk) disable iff (!nrst)
        (wr_flag && hit == 8'h00)
        |=> (edge_flag_bits_q == ($past(edge_flag_bits_q) & $past(reg_wdata[7:0]))))
        else $error("flag write of zero did not clear");

    a_set_wins: assert property (
        @(posedge clk) disable iff (!nrst)
        (wr_flag && hit != 8'h00) |=> ((edge_flag_bits_q & $past(hit)) == $past(hit)))
        else $error("clear beat a new edge");

    a_no_false_set: assert property (
        @(posedge clk) disable iff (!nrst)
        1'b1 |=> ((edge_flag_bits_q & ~$past(edge_flag_bits_q) & ~$past(hit)) == 8'h00))
        else $error("flag set without an edge");

    a_flag_keep_one: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_flag |=> ((edge_flag_bits_q & $past(edge_flag_bits_q) & $past(reg_wdata[7:0]))
            == ($past(edge_flag_bits_q) & $past(reg_wdata[7:0]))))
        else $error("written one cleared a flag");

    a_flag_reset: assert property (
        @(posedge clk)
        !nrst |=> (edge_flag_bits_q == 8'h00))
        else $error("flags not cleared by reset");

    // Edge select register behaviour.
    a_sel_reset: assert property (
        @(posedge clk)
        !nrst |=> (edge_select_control_q == 16'h0000))
        else $error("edge select not cleared by reset");

    a_sel_byte: assert property (
        @(posedge clk) disable iff (!nrst)
        (reg_wr && !reg_word) |=> $stable(edge_select_control_q))
        else $error("byte write changed edge select");

    a_sel_write: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_sel |=> (edge_select_control_q == $past(reg_wdata)))
        else $error("word write did not load edge select");

    a_sel_other: assert property (
        @(posedge clk) disable iff (!nrst)
        (reg_wr && reg_addr != PTD_ADDR_SEL) |=> $stable(edge_select_control_q))
        else $error("write elsewhere changed edge select");

    a_sel_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        !wr_sel |=> $stable(edge_select_control_q))
        else $error("edge select changed without a write");

    // Detection path.
    a_fall_detect: assert property (
        @(posedge clk) disable iff (!nrst)
        (edge_select_control_q[1:0] == 2'h0 && prev_q[0] && !sync2_q[0]) |-> hit[0])
        else $error("falling edge missed");

    a_pin_path: assert property (
        @(posedge clk) disable iff (!nrst)
        (edge_select_control_q[1:0] == 2'h1 && $stable(edge_select_control_q)
         && !sync1_q[0] ##1 sync1_q[0] && $stable(edge_select_control_q)) |=> hit[0])
        else $error("synchronised rising edge missed");

    a_sync_second: assert property (
        @(posedge clk) disable iff (!nrst)
        1'b1 |=> (sync2_q == $past(sync1_q)))
        else $error("second synchroniser stage skipped");

    a_sync_prev: assert property (
        @(posedge clk) disable iff (!nrst)
        1'b1 |=> (prev_q == $past(sync2_q)))
        else $error("previous sample stage skipped");

    a_sync_reset: assert property (
        @(posedge clk)
        !nrst |=> (sync2_q == 8'h00 && prev_q == 8'h00))
        else $error("pin history not cleared by reset");

    // Each channel decodes its own two-bit field.
    for (genvar g = 0; g < PTD_CH; g++) begin : g_chan_chk
        a_rise_hit: assert property (
            @(posedge clk) disable iff (!nrst)
            (edge_select_control_q[g*PTD_SEL_W +: PTD_SEL_W] == PTD_EDGE_RISE
             && !prev_q[g] && sync2_q[g]) |-> hit[g])
            else $error("rising edge missed");

        a_rise_only: assert property (
            @(posedge clk) disable iff (!nrst)
            (edge_select_control_q[g*PTD_SEL_W +: PTD_SEL_W] == PTD_EDGE_RISE
             && prev_q[g] && !sync2_q[g]) |-> !hit[g])
            else $error("falling edge taken in rise mode");

        a_fall_only: assert property (
            @(posedge clk) disable iff (!nrst)
            (edge_select_control_q[g*PTD_SEL_W +: PTD_SEL_W] == PTD_EDGE_FALL
             && !prev_q[g] && sync2_q[g]) |-> !hit[g])
            else $error("rising edge taken in fall mode");

        a_both_hit: assert property (
            @(posedge clk) disable iff (!nrst)
            (edge_select_control_q[g*PTD_SEL_W +: PTD_SEL_W] == PTD_EDGE_BOTH
             && (prev_q[g] ^ sync2_q[g])) |-> hit[g])
            else $error("edge missed in both mode");

        a_idle_quiet: assert property (
            @(posedge clk) disable iff (!nrst)
            (prev_q[g] == sync2_q[g]) |-> !hit[g])
            else $error("edge seen on a steady pin");
    end

    // Register port and interrupt.
    a_flag_read: assert property (
        @(posedge clk) disable iff (!nrst)
        (reg_rd && reg_addr == PTD_ADDR_FLAG)
        |=> (reg_rdata == {8'h00, $past(edge_flag_bits_q)}))
        else $error("flag read data wrong");

    a_sel_read: assert property (
        @(posedge clk) disable iff (!nrst)
        (reg_rd && reg_word && reg_addr == PTD_ADDR_SEL)
        |=> (reg_rdata == $past(edge_select_control_q)))
        else $error("edge select read data wrong");

    a_sel_byte_read: assert property (
        @(posedge clk) disable iff (!nrst)
        (reg_rd && !reg_word && reg_addr == PTD_ADDR_SEL) |=> (reg_rdata == 16'h0000))
        else $error("byte read of edge select not zero");

    a_rdata_idle: assert property (
        @(posedge clk) disable iff (!nrst)
        !reg_rd |=> (reg_rdata == 16'h0000))
        else $error("read data without a read");

    a_mask_write: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_mask |=> (mask_q == $past(reg_wdata[7:0])))
        else $error("mask write did not land");

    a_mask_reset: assert property (
        @(posedge clk)
        !nrst |=> (mask_q == PTD_MASK_RST))
        else $error("mask not cleared by reset");

    a_irq_reset: assert property (
        @(posedge clk)
        !nrst |=> !irq)
        else $error("interrupt not cleared by reset");

    a_irq_masked: assert property (
        @(posedge clk) disable iff (!nrst)
        (mask_q == 8'h00) |-> !irq)
        else $error("interrupt with all channels masked");

    a_irq_level: assert property (
        @(posedge clk) disable iff (!nrst)
        ##1 (irq == |(edge_flag_bits_q & mask_q)))
        else $error("interrupt level mismatch");
endmodule : ptd_top

/* File: ptd_src.sv */
// Model of the external sources that drive the edge input pins.
`timescale 1ns/1ps
module ptd_src (
    // Clock.
    input wire logic clk,
    // Pin levels.
    output logic [7:0] pins
);
    initial pins = 8'h00;
    // Levels change just after a clock edge and then hold.
    task automatic put(input logic [7:0] v);
        @(posedge clk);
        pins <= v;
    endtask : put
endmodule : ptd_src

/* File: tb.sv */
// Self-checking testbench of the pin transition detector.
`timescale 1ns/1ps
module tb;
    import ptd_pkg::*;
    logic clk = 0, nrst = 0, wr = 0, rd = 0, wd = 1, irq;
    logic [8:0] a = 9'h000;
    logic [15:0] d = 16'h0000, q;
    logic [7:0] pins;
    int errors = 0, n_checks = 0;
    ptd_src ptd_src_inst (.clk(clk), .pins(pins));
    ptd_top ptd_top_inst (.clk(clk), .nrst(nrst), .edge_input_pins(pins), .reg_addr(a),
        .reg_wdata(d), .reg_wr(wr), .reg_rd(rd), .reg_word(wd), .reg_rdata(q), .irq(irq));
    initial forever #4 clk = ~clk;
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wrt(input logic [8:0] ad, input logic [15:0] v, input logic w);
        @(posedge clk);
        a <= ad;
        d <= v;
        wd <= w;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrt
    task automatic rdc(input string s, input logic [8:0] ad, input logic w, input logic [15:0] e);
        @(posedge clk);
        a <= ad;
        wd <= w;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(s, e, q);
    endtask : rdc
    // Two synchroniser stages plus the flag register need a few cycles.
    task automatic pin(input logic [7:0] v);
        ptd_src_inst.put(v);
        repeat (4) @(posedge clk);
    endtask : pin
    task automatic t_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rdc("flags", PTD_ADDR_FLAG, 1'b0, 16'h0000);
        rdc("select", PTD_ADDR_SEL, 1'b1, 16'h0000);
        #1 chk("irq", 16'h0000, {15'h0000, irq});
        $display("t_reset done");
    endtask : t_reset
    task automatic t_fall();
        wrt(PTD_ADDR_FLAG, 16'h0000, 1'b0);
        pin(8'hFF);
        rdc("flags rise", PTD_ADDR_FLAG, 1'b0, 16'h0000);
        pin(8'h00);
        rdc("flags fall", PTD_ADDR_FLAG, 1'b0, 16'h00FF);
        wrt(PTD_ADDR_FLAG, 16'h000F, 1'b0);
        rdc("flags kept", PTD_ADDR_FLAG, 1'b0, 16'h000F);
        $display("t_fall done");
    endtask : t_fall
    task automatic t_modes();
        wrt(PTD_ADDR_SEL, 16'h1111, 1'b0);
        rdc("select byte wr", PTD_ADDR_SEL, 1'b1, 16'h0000);
        wrt(PTD_ADDR_SEL, 16'hE4E4, 1'b1);
        rdc("select", PTD_ADDR_SEL, 1'b1, 16'hE4E4);
        rdc("select byte rd", PTD_ADDR_SEL, 1'b0, 16'h0000);
        wrt(PTD_ADDR_FLAG, 16'h0000, 1'b0);
        pin(8'hFF);
        rdc("rise", PTD_ADDR_FLAG, 1'b0, 16'h00EE);
        wrt(PTD_ADDR_FLAG, 16'h0000, 1'b0);
        pin(8'h00);
        rdc("fall", PTD_ADDR_FLAG, 1'b0, 16'h00DD);
        $display("t_modes done");
    endtask : t_modes
    task automatic t_irq();
        wrt(PTD_ADDR_MASK, 16'h0001, 1'b0);
        repeat (2) @(posedge clk);
        #1 chk("irq on", 16'h0001, {15'h0000, irq});
        wrt(PTD_ADDR_MASK, 16'h0022, 1'b0);
        repeat (2) @(posedge clk);
        #1 chk("irq off", 16'h0000, {15'h0000, irq});
        rdc("unmapped", 9'h100, 1'b1, 16'h0000);
        $display("t_irq done");
    endtask : t_irq
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    initial begin
        t_reset();
        t_fall();
        t_modes();
        t_irq();
        t_reset();
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        complete_run();
    end
endmodule : tb
